// ==== zero_return_sequencer.sv ====
// two-axis mechanical zero return sequencer with apb registers
//
// Implementation choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/100ps
module zero_return_sequencer
    import zero_return_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [zero_return_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // servo side inputs
    input wire logic [zero_return_pkg::AXES-1:0] index_pass,
    input wire logic [zero_return_pkg::AXES-1:0] sensor_amp,
    input wire logic [zero_return_pkg::AXES-1:0] sensor_mod,
    input wire logic [zero_return_pkg::AXES-1:0] limit_hit,
    input wire logic [zero_return_pkg::AXES-1:0][zero_return_pkg::SPD_W-1:0]
        torque_fb,
    // motion commands
    output logic [zero_return_pkg::AXES-1:0][zero_return_pkg::SPD_W:0]
        vel_cmd,
    output logic [zero_return_pkg::AXES-1:0][zero_return_pkg::SPD_W-1:0]
        torque_lim,
    output logic [zero_return_pkg::AXES-1:0] torque_lim_en
);
    import zero_return_pkg::*;

    logic [CTRL_W-1:0] ctrl, next_ctrl;
    logic [1:0] cmd_prev, next_cmd_prev;
    logic [AXES-1:0] start_req;
    logic [AXES-1:0] sensor;
    logic [AXES-1:0] accept;
    logic wr_en;
    logic [31:0] next_prdata;
    logic next_pready, next_pslverr;
    logic [2:0] base;
    logic [4:0] loc;
    logic mapped_axis;
    logic rd_axis;

    axis_state_t st [AXES], next_st [AXES];
    logic [CFG_W-1:0] cfg [AXES], next_cfg [AXES];
    logic [POS_W-1:0] zp [AXES], next_zp [AXES];
    logic [POS_W-1:0] cur_pos [AXES], next_cur_pos [AXES];
    logic [SPD_W-1:0] hspd [AXES], next_hspd [AXES];
    logic [SPD_W-1:0] act_hspd [AXES], next_act_hspd [AXES];
    logic [SPD_W-1:0] creep [AXES], next_creep [AXES];
    logic [SPD_W-1:0] trq [AXES], next_trq [AXES];
    logic [1:0] mode [AXES], next_mode [AXES];
    logic [4:0] stat [AXES], next_stat [AXES];
    logic [SPD_W:0] next_vel [AXES];
    logic [SPD_W-1:0] next_tlim [AXES];
    logic [AXES-1:0] next_tlim_en;
    logic [AXES-1:0] wr_axis;

    assign base = paddr[7:5];
    assign loc = paddr[4:0];
    assign mapped_axis = (base == BASE_X) || (base == BASE_Y);
    assign rd_axis = (base == BASE_Y);
    assign wr_en = psel && penable && pready && pwrite;
    assign wr_axis[0] = wr_en && (base == BASE_X);
    assign wr_axis[1] = wr_en && (base == BASE_Y);

    // apb answer: no wait state, pready high in the first access cycle, data prepared in setup
    always_comb begin
        next_pready = psel && !penable;
        next_pslverr = 1'b0;
        next_prdata = RD_ZERO;
        if (paddr == OFF_CTRL) begin
            next_prdata = {{(32-CTRL_W){1'b0}}, ctrl};
        end else if (mapped_axis && loc == OFF_CFG) begin
            next_prdata = {{(32-CFG_W){1'b0}}, cfg[rd_axis]};
        end else if (mapped_axis && loc == OFF_ZP) begin
            next_prdata = zp[rd_axis];
        end else if (mapped_axis && loc == OFF_HSPD) begin
            next_prdata = {{(32-SPD_W){1'b0}}, hspd[rd_axis]};
        end else if (mapped_axis && loc == OFF_CREEP) begin
            next_prdata = {{(32-SPD_W){1'b0}}, creep[rd_axis]};
        end else if (mapped_axis && loc == OFF_TRQ) begin
            next_prdata = {{(32-SPD_W){1'b0}}, trq[rd_axis]};
        end else if (mapped_axis && loc == OFF_SPDCHG) begin
            next_prdata = {{(32-SPD_W){1'b0}}, act_hspd[rd_axis]};
        end else if (mapped_axis && loc == OFF_STATUS) begin
            next_prdata = {{27{1'b0}}, stat[rd_axis]};
        end else if (mapped_axis && loc == OFF_CURPOS) begin
            next_prdata = cur_pos[rd_axis];
        end else begin
            next_pslverr = psel && !penable;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= RD_ZERO;
        end else begin
            pready <= next_pready;
            pslverr <= next_pslverr;
            prdata <= next_prdata;
        end
    end

    // control register and command edge detection
    always_comb begin
        next_ctrl = ctrl;
        if (wr_en && paddr == OFF_CTRL) begin
            next_ctrl = pwdata[CTRL_W-1:0];
        end
        next_cmd_prev = {ctrl[CTRL_CMD_Y], ctrl[CTRL_CMD_X]};
        start_req[0] = ctrl[CTRL_CMD_X] && !cmd_prev[0];
        start_req[1] = ctrl[CTRL_SIMUL] ? start_req[0] :
            (ctrl[CTRL_CMD_Y] && !cmd_prev[1]);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= {CTRL_W{1'b0}};
            cmd_prev <= 2'h0;
        end else begin
            ctrl <= next_ctrl;
            cmd_prev <= next_cmd_prev;
        end
    end

    // per-axis configuration and sequencer
    always_comb begin
        for (int i = 0; i < AXES; i++) begin
            next_cfg[i] = cfg[i];
            next_zp[i] = zp[i];
            next_hspd[i] = hspd[i];
            next_act_hspd[i] = act_hspd[i];
            next_creep[i] = creep[i];
            next_trq[i] = trq[i];
            next_cur_pos[i] = cur_pos[i];
            next_mode[i] = mode[i];
            next_stat[i] = stat[i];
            next_st[i] = st[i];
            // sensor source and polarity
            sensor[i] = (cfg[i][CFG_SEL] ? sensor_mod[i] : sensor_amp[i])
                ^ cfg[i][CFG_POL];
            accept[i] = start_req[i] && index_pass[i]
                && st[i] == AX_IDLE && cfg[i][CFG_MODE_LO +: 2] != MODE_BAD;
            if (wr_axis[i] && loc == OFF_CFG) begin
                next_cfg[i] = pwdata[CFG_W-1:0];
            end
            if (wr_axis[i] && loc == OFF_ZP) begin
                next_zp[i] = pwdata;
            end
            if (wr_axis[i] && loc == OFF_HSPD) begin
                next_hspd[i] = pwdata[SPD_W-1:0];
            end
            if (wr_axis[i] && loc == OFF_CREEP) begin
                next_creep[i] = pwdata[SPD_W-1:0];
            end
            if (wr_axis[i] && loc == OFF_TRQ) begin
                next_trq[i] = pwdata[SPD_W-1:0];
            end
            if (wr_axis[i] && loc == OFF_SPDCHG && !ctrl[CTRL_SPD_LOCK]) begin
                next_act_hspd[i] = pwdata[SPD_W-1:0];
            end
            if (start_req[i] && !accept[i]) begin
                next_stat[i][ST_REJECT] = 1'b1;
            end
            case (st[i])
                AX_IDLE: begin
                    if (accept[i]) begin
                        next_mode[i] = cfg[i][CFG_MODE_LO +: 2];
                        next_stat[i] = 5'h00;
                        next_act_hspd[i] = hspd[i];
                        if (cfg[i][CFG_MODE_LO +: 2] == MODE_DATASET) begin
                            next_cur_pos[i] = zp[i];
                            next_stat[i][ST_ZR_DONE] = 1'b1;
                        end else if (cfg[i][CFG_MODE_LO +: 2] == MODE_STOP1) begin
                            next_st[i] = AX_HIGH;
                        end else begin
                            next_st[i] = AX_CREEP;
                        end
                    end
                end
                AX_HIGH: begin
                    if (sensor[i]) begin
                        next_st[i] = AX_CREEP;
                    end else if (limit_hit[i] && mode[i] == MODE_STOP1) begin
                        next_st[i] = AX_IDLE;
                        next_stat[i][ST_LIM_ERR] = 1'b1;
                    end
                end
                AX_CREEP: begin
                    if (torque_fb[i] >= trq[i]) begin
                        next_st[i] = AX_STOP;
                    end
                end
                AX_STOP: begin
                    next_cur_pos[i] = zp[i];
                    next_stat[i][ST_ZR_DONE] = 1'b1;
                    next_stat[i][ST_POS_DONE] = 1'b1;
                    next_st[i] = AX_IDLE;
                end
                default: begin
                    next_st[i] = AX_IDLE;
                end
            endcase
            next_stat[i][ST_BUSY] = next_st[i] != AX_IDLE;
            // motion outputs follow the next state
            next_vel[i] = {(SPD_W+1){1'b0}};
            if (next_st[i] == AX_HIGH) begin
                next_vel[i] = {1'b0, next_act_hspd[i]};
            end else if (next_st[i] == AX_CREEP) begin
                next_vel[i] = {1'b0, creep[i]};
            end
            if (!cfg[i][CFG_DIR]) begin
                next_vel[i] = -next_vel[i];
            end
            next_tlim_en[i] = next_st[i] == AX_CREEP;
            next_tlim[i] = next_tlim_en[i] ? next_trq[i] : SPD_RST;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < AXES; i++) begin
                st[i] <= AX_IDLE;
                cfg[i] <= CFG_RST;
                zp[i] <= POS_RST;
                cur_pos[i] <= POS_RST;
                hspd[i] <= SPD_RST;
                act_hspd[i] <= SPD_RST;
                creep[i] <= SPD_RST;
                trq[i] <= SPD_RST;
                mode[i] <= MODE_DATASET;
                stat[i] <= 5'h00;
                vel_cmd[i] <= {(SPD_W+1){1'b0}};
                torque_lim[i] <= SPD_RST;
            end
            torque_lim_en <= {AXES{1'b0}};
        end else begin
            for (int i = 0; i < AXES; i++) begin
                st[i] <= next_st[i];
                cfg[i] <= next_cfg[i];
                zp[i] <= next_zp[i];
                cur_pos[i] <= next_cur_pos[i];
                hspd[i] <= next_hspd[i];
                act_hspd[i] <= next_act_hspd[i];
                creep[i] <= next_creep[i];
                trq[i] <= next_trq[i];
                mode[i] <= next_mode[i];
                stat[i] <= next_stat[i];
                vel_cmd[i] <= next_vel[i];
                torque_lim[i] <= next_tlim[i];
            end
            torque_lim_en <= next_tlim_en;
        end
    end

    // checks on axis 0 and the axis pairing
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    index_reject_a: assert property (
        start_req[0] && !index_pass[0] && st[0] == AX_IDLE
        |=> st[0] == AX_IDLE && stat[0][ST_REJECT] && vel_cmd[0] == '0)
        else $error("zero return accepted without index pass");
    dataset_load_a: assert property (
        accept[0] && cfg[0][CFG_MODE_LO +: 2] == MODE_DATASET
        |=> cur_pos[0] == $past(zp[0]) && stat[0][ST_ZR_DONE]
        && !stat[0][ST_POS_DONE] && st[0] == AX_IDLE && vel_cmd[0] == '0)
        else $error("data-set zero return wrong");
    limit_abort_a: assert property (
        st[0] == AX_HIGH && !sensor[0] && limit_hit[0]
        |=> st[0] == AX_IDLE && stat[0][ST_LIM_ERR] && vel_cmd[0] == '0)
        else $error("limit during search not reported");
    sensor_creep_a: assert property (
        st[0] == AX_HIGH && sensor[0]
        |=> st[0] == AX_CREEP && torque_lim_en[0])
        else $error("sensor did not slow axis to creep");
    mode1_start_a: assert property (
        accept[0] && cfg[0][CFG_MODE_LO +: 2] == MODE_STOP1
        |=> st[0] == AX_HIGH && vel_cmd[0] != '0
        && vel_cmd[0][SPD_W] == !$past(cfg[0][CFG_DIR]))
        else $error("stopper mode 1 start wrong");
    mode2_start_a: assert property (
        accept[0] && cfg[0][CFG_MODE_LO +: 2] == MODE_STOP2
        |=> st[0] == AX_CREEP ##0 st[0] != AX_HIGH [*2])
        else $error("stopper mode 2 did not run at creep");
    stop_complete_a: assert property (
        st[0] == AX_CREEP && torque_fb[0] >= trq[0]
        |=> st[0] == AX_STOP ##1 st[0] == AX_IDLE
        && cur_pos[0] == zp[0] && stat[0][ST_POS_DONE] && stat[0][ST_ZR_DONE])
        else $error("stopper completion wrong");
    creep_torque_a: assert property (
        torque_lim_en[0] == (st[0] == AX_CREEP)
        && (!torque_lim_en[0] || torque_lim[0] == trq[0]))
        else $error("torque limit not applied at creep");
    simul_start_a: assert property (
        ctrl[CTRL_SIMUL] && accept[0] && index_pass[1] && st[1] == AX_IDLE
        && cfg[1][CFG_MODE_LO +: 2] != MODE_BAD
        |=> !stat[1][ST_REJECT] && (stat[1][ST_BUSY] || stat[1][ST_ZR_DONE]))
        else $error("simultaneous start missed second axis");
    speed_lock_a: assert property (
        wr_axis[0] && loc == OFF_SPDCHG && ctrl[CTRL_SPD_LOCK]
        && !accept[0] |=> $stable(act_hspd[0]))
        else $error("speed changed while locked");

    dataset_c: cover property (accept[0]
        && cfg[0][CFG_MODE_LO +: 2] == MODE_DATASET);
    stop1_c: cover property (st[0] == AX_HIGH ##[1:50] st[0] == AX_STOP);
    both_c: cover property (ctrl[CTRL_SIMUL] && accept[0] && accept[1]);
    abort_c: cover property (st[0] == AX_HIGH ##1 stat[0][ST_LIM_ERR]);
endmodule

// ==== zero_return_pkg.sv ====
// constants for the mechanical zero return sequencer
package zero_return_pkg;
    localparam int AXES = 2;
    localparam int SPD_W = 16;
    localparam int POS_W = 32;
    localparam int ADDR_W = 8;
    // register map
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [2:0] BASE_X = 3'h1;
    localparam logic [2:0] BASE_Y = 3'h2;
    localparam logic [4:0] OFF_CFG = 5'h00;
    localparam logic [4:0] OFF_ZP = 5'h04;
    localparam logic [4:0] OFF_HSPD = 5'h08;
    localparam logic [4:0] OFF_CREEP = 5'h0c;
    localparam logic [4:0] OFF_TRQ = 5'h10;
    localparam logic [4:0] OFF_SPDCHG = 5'h14;
    localparam logic [4:0] OFF_STATUS = 5'h18;
    localparam logic [4:0] OFF_CURPOS = 5'h1c;
    // control bits
    localparam int CTRL_CMD_X = 0;
    localparam int CTRL_CMD_Y = 1;
    localparam int CTRL_SIMUL = 2;
    localparam int CTRL_SPD_LOCK = 3;
    localparam int CTRL_W = 4;
    // axis configuration bits
    localparam int CFG_MODE_LO = 0;
    localparam int CFG_DIR = 10;
    localparam int CFG_POL = 12;
    localparam int CFG_SEL = 14;
    localparam int CFG_W = 15;
    // status bits
    localparam int ST_ZR_DONE = 0;
    localparam int ST_POS_DONE = 1;
    localparam int ST_BUSY = 2;
    localparam int ST_LIM_ERR = 3;
    localparam int ST_REJECT = 4;
    // zero return modes
    localparam logic [1:0] MODE_DATASET = 2'h0;
    localparam logic [1:0] MODE_STOP1 = 2'h1;
    localparam logic [1:0] MODE_STOP2 = 2'h2;
    localparam logic [1:0] MODE_BAD = 2'h3;
    // reset values
    localparam logic [CFG_W-1:0] CFG_RST = 15'h0000;
    localparam logic [SPD_W-1:0] SPD_RST = 16'h0000;
    localparam logic [POS_W-1:0] POS_RST = 32'h0000_0000;
    localparam logic [31:0] RD_ZERO = 32'h0000_0000;

    typedef enum logic [3:0] {
        AX_IDLE = 4'h1,
        AX_HIGH = 4'h2,
        AX_CREEP = 4'h4,
        AX_STOP = 4'h8
    } axis_state_t;
endpackage

// ==== servo_model.sv ====
// servo amplifier model with encoder index and near point sensor
`timescale 1ns/100ps
module servo_model
    import zero_return_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // bench controls
    input wire logic func_sel,
    input wire logic no_sensor,
    // from sequencer
    input wire logic [zero_return_pkg::AXES-1:0][zero_return_pkg::SPD_W:0]
        vel_cmd,
    input wire logic [zero_return_pkg::AXES-1:0] torque_lim_en,
    // to sequencer
    output logic [zero_return_pkg::AXES-1:0] index_pass,
    output logic [zero_return_pkg::AXES-1:0] sensor_amp,
    output logic [zero_return_pkg::AXES-1:0] limit_hit,
    output logic [zero_return_pkg::AXES-1:0][zero_return_pkg::SPD_W-1:0]
        torque_fb
);
    int travel [AXES];
    logic crossed;
    // travel in cycles since motion began
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            crossed <= 1'b0;
            for (int i = 0; i < AXES; i++) travel[i] <= 0;
        end else begin
            for (int i = 0; i < AXES; i++) begin
                travel[i] <= (vel_cmd[i] == '0) ? 0 : travel[i] + 1;
                if (travel[i] >= 2 && !func_sel) crossed <= 1'b1;
            end
        end
    end
    always_comb begin
        for (int i = 0; i < AXES; i++) begin
            index_pass[i] = func_sel | crossed;
            sensor_amp[i] = !no_sensor && travel[i] >= 4;
            limit_hit[i] = !torque_lim_en[i] && travel[i] >= 8;
            torque_fb[i] = (torque_lim_en[i] && travel[i] >= 10) ?
                16'h0fff : 16'h0010;
        end
    end
endmodule

// ==== mechanical_zero_return_sequencer_test.sv ====
// self-checking bench for the zero return sequencer
`timescale 1ns/100ps
module mechanical_zero_return_sequencer_test;
    import zero_return_pkg::*;
    typedef struct packed {
        logic [CFG_W-1:0] cfg;
        logic fs;
        logic ns;
        logic [SPD_W:0] vel;
        logic [4:0] st;
        logic [SPD_W-1:0] tl;
    } row_t;
    localparam logic [31:0] ZP = 32'h1234_5678;
    localparam logic [SPD_W-1:0] HS = 16'h0200;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [ADDR_W-1:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic pready, pslverr, err, func_sel = 1'b1, no_sensor = 1'b0;
    logic [AXES-1:0] index_pass, sensor_amp, limit_hit, torque_lim_en;
    logic [AXES-1:0] sensor_mod = '0;
    logic [AXES-1:0][SPD_W-1:0] torque_fb, torque_lim;
    logic [AXES-1:0][SPD_W:0] vel_cmd;
    logic [SPD_W:0] first_vel = '0;
    logic [SPD_W-1:0] seen_tl = '0;
    int fail_count = 0, compares = 0;
    row_t rows [9];

    always #50 pclk = ~pclk;

    zero_return_sequencer zero_return_sequencer_inst (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .index_pass(index_pass), .sensor_amp(sensor_amp),
        .sensor_mod(sensor_mod), .limit_hit(limit_hit),
        .torque_fb(torque_fb), .vel_cmd(vel_cmd), .torque_lim(torque_lim),
        .torque_lim_en(torque_lim_en));

    servo_model servo_model_inst (.pclk(pclk), .presetn(presetn),
        .func_sel(func_sel), .no_sensor(no_sensor), .vel_cmd(vel_cmd),
        .torque_lim_en(torque_lim_en), .index_pass(index_pass),
        .sensor_amp(sensor_amp), .limit_hit(limit_hit),
        .torque_fb(torque_fb));

    // first velocity and creep torque limit of axis x
    always @(posedge pclk) begin
        if (vel_cmd[0] !== '0 && first_vel === '0) first_vel <= vel_cmd[0];
        if (torque_lim_en[0] === 1'b1) seen_tl <= torque_lim[0];
    end

    function automatic logic [7:0] ax(logic [2:0] b, logic [4:0] o);
        return {b, o};
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp,
        input string msg);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t %s got %h exp %h", $time, msg,
                seen, exp);
        end
    endtask

    task automatic summarize;
        $display("compares %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // apb transfer, entered just after a rising edge
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rdr(input logic [7:0] a);
        apb(1'b0, a, 32'h0);
    endtask

    // command edge, then poll axis x until idle
    task automatic go(input logic [31:0] c);
        int n;
        wr(OFF_CTRL, 32'h0);
        wr(OFF_CTRL, c);
        repeat (4) @(posedge pclk);
        n = 0;
        do begin
            rdr(ax(BASE_X, OFF_STATUS));
            n++;
        end while (rd[ST_BUSY] !== 1'b0 && n < 100);
        check(32'(n < 100), 32'h1, "return did not finish");
    endtask

    initial begin
        #3_000_000;
        fail_count++;
        $display("CHECK FAILED t=%0t watchdog expired", $time);
        summarize();
    end

    initial begin
        rows = '{
            '{15'h0000, 1'b1, 1'b0, 17'h00000, 5'h01, 16'h0000},
            '{15'h0001, 1'b1, 1'b0, 17'h1fe00, 5'h03, 16'h0800},
            '{15'h0401, 1'b1, 1'b0, 17'h00200, 5'h03, 16'h0800},
            '{15'h0402, 1'b1, 1'b0, 17'h00020, 5'h03, 16'h0800},
            '{15'h5001, 1'b1, 1'b1, 17'h1fe00, 5'h03, 16'h0800},
            '{15'h4001, 1'b1, 1'b0, 17'h1fe00, 5'h08, 16'h0000},
            '{15'h0003, 1'b1, 1'b0, 17'h00000, 5'h18, 16'h0000},
            '{15'h0001, 1'b0, 1'b0, 17'h00000, 5'h18, 16'h0000},
            '{15'h0000, 1'b0, 1'b0, 17'h00000, 5'h18, 16'h0000}};
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rdr(ax(BASE_X, OFF_CFG));
        check(rd, {17'h0, CFG_RST}, "cfg reset");
        rdr(ax(BASE_X, OFF_STATUS));
        check(rd, RD_ZERO, "status reset");
        rdr(8'h60);
        check({31'h0, err}, 32'h1, "unmapped error");
        check(rd, RD_ZERO, "unmapped data");
        wr(ax(BASE_X, OFF_ZP), ZP);
        wr(ax(BASE_X, OFF_HSPD), {16'h0, HS});
        wr(ax(BASE_X, OFF_CREEP), 32'h0000_0020);
        wr(ax(BASE_X, OFF_TRQ), 32'h0000_0800);
        $display("test reset and unmapped done");
        foreach (rows[i]) begin
            func_sel <= rows[i].fs;
            no_sensor <= rows[i].ns;
            wr(ax(BASE_X, OFF_CFG), {17'h0, rows[i].cfg});
            first_vel = '0;
            seen_tl = '0;
            go(32'h1 << CTRL_CMD_X);
            check(rd, {27'h0, rows[i].st}, "status");
            check({15'h0, first_vel}, {15'h0, rows[i].vel}, "velocity");
            check({16'h0, seen_tl}, {16'h0, rows[i].tl}, "torque limit");
            rdr(ax(BASE_X, OFF_CURPOS));
            check(rd, ZP, "position");
            $display("test row %0d done", i);
        end
        func_sel <= 1'b1;
        go(32'h1 << CTRL_SIMUL | 32'h1 << CTRL_CMD_Y);
        rdr(ax(BASE_Y, OFF_STATUS));
        check(rd, RD_ZERO, "second axis ignored");
        go(32'h1 << CTRL_SIMUL | 32'h1 << CTRL_CMD_X);
        rdr(ax(BASE_Y, OFF_STATUS));
        check(rd, 32'h1, "second axis started");
        rdr(ax(BASE_X, OFF_STATUS));
        check(rd, 32'h1, "first axis started");
        $display("test simultaneous start done");
        wr(OFF_CTRL, 32'h1 << CTRL_SPD_LOCK);
        wr(ax(BASE_X, OFF_SPDCHG), 32'h0000_0055);
        rdr(ax(BASE_X, OFF_SPDCHG));
        check(rd, {16'h0, HS}, "locked speed");
        wr(OFF_CTRL, 32'h0);
        wr(ax(BASE_X, OFF_SPDCHG), 32'h0000_0066);
        rdr(ax(BASE_X, OFF_SPDCHG));
        check(rd, 32'h0000_0066, "changed speed");
        $display("test speed lock done");
        summarize();
    end
endmodule
